// *** ahs_setup_cmd.sv ***
// Setup command handler: frame parser, calibration captures, slew and speed selection
`default_nettype none
module ahs_setup_cmd
  import ahs_pkg::*;
#(
  parameter longint STARTUP_CYC = AHS_STARTUP_CYC
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Received bytes from the link
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Live accelerometer readings
  input wire logic [15:0] accel_x,
  input wire logic [15:0] accel_y,
  input wire logic [15:0] accel_z,
  // Bias search done at startup, and external velocity presence timeout at any time
  input wire logic bias_done,
  input wire logic vel_lost,
  // Filter engine controls
  output logic level_req,
  output logic startup_busy,
  output logic [15:0] x_one_g,
  output logic [15:0] z_zero_g,
  output logic [15:0] y_one_g,
  output logic [15:0] slew_factor_word,
  output logic [15:0] speed_mph,
  output logic vel_external,
  output logic reduced_comp,
  output logic ack_pulse
);
  ahs_state_t st_q, st_d;
  logic [7:0] len_q, len_d, cat_q, cat_d, fn_q, fn_d, cnt_q, cnt_d, b0_q, b0_d, b1_q, b1_d;
  logic [15:0] xg_q, xg_d, zg_q, zg_d, yg_q, yg_d, sf_q, sf_d, vel_q, vel_d, spd_q, spd_d;
  logic ext_q, ext_d, lvl_q, lvl_d, ack_q, ack_d, busy_q, busy_d, red_q, red_d;
  logic [31:0] up_q, up_d;
  logic [15:0] dflt;

  // Default speed by slew factor band; anything above the top step takes the top speed
  always_comb
  begin
    if (sf_q < AHS_SF_LOW)
      dflt = AHS_SPD_LOWEST;
    else if (sf_q < AHS_SF_MED)
      dflt = AHS_SPD_LOW;
    else if (sf_q < AHS_SF_HIGH)
      dflt = AHS_SPD_MED;
    else if (sf_q < AHS_SF_TOP)
      dflt = AHS_SPD_HIGH;
    else
      dflt = AHS_SPD_TOP;
  end

  always_comb
  begin
    st_d = st_q;
    len_d = len_q;
    cat_d = cat_q;
    fn_d = fn_q;
    cnt_d = cnt_q;
    b0_d = b0_q;
    b1_d = b1_q;
    xg_d = xg_q;
    zg_d = zg_q;
    yg_d = yg_q;
    sf_d = sf_q;
    vel_d = vel_q;
    ext_d = ext_q && !vel_lost;
    lvl_d = 1'b0;
    ack_d = 1'b0;
    up_d = up_q;
    busy_d = busy_q;
    // Startup window: bias search, closed by bias_done with a levelling request, capped at its time budget
    if (busy_q)
    begin
      up_d = up_q + 32'd1;
      if (bias_done || up_q >= 32'(STARTUP_CYC - 1))
      begin
        busy_d = 1'b0;
        lvl_d = 1'b1;
      end
    end
    if (rx_valid)
    begin
      case (st_q)
        AHS_ST_DEST:
          if (rx_byte == AHS_DEST_IMU)
            st_d = AHS_ST_LEN;
        AHS_ST_LEN:
        begin
          len_d = rx_byte;
          st_d = AHS_ST_CAT;
        end
        AHS_ST_CAT:
        begin
          cat_d = rx_byte;
          st_d = AHS_ST_FN;
        end
        AHS_ST_FN:
        begin
          fn_d = rx_byte;
          cnt_d = len_q - AHS_LEN_SHORT;
          if (cat_q != AHS_CAT_SETUP && !(cat_q == AHS_CAT_VEL && rx_byte == AHS_FN_VEL))
            st_d = (len_q > AHS_LEN_SHORT) ? AHS_ST_SKIP : AHS_ST_DEST;
          else if (len_q > AHS_LEN_SHORT)
            st_d = AHS_ST_PAY;
          else
          begin
            st_d = AHS_ST_DEST;
            if (len_q == AHS_LEN_SHORT)
            begin
              case (rx_byte)
                AHS_FN_LEVEL:
                begin
                  lvl_d = 1'b1;
                  ack_d = 1'b1;
                end
                AHS_FN_XCAL:
                begin
                  xg_d = accel_x;
                  zg_d = accel_z;
                  ack_d = 1'b1;
                end
                AHS_FN_YCAL:
                begin
                  yg_d = accel_y;
                  ack_d = 1'b1;
                end
                default:
                begin
                end
              endcase
            end
          end
        end
        AHS_ST_PAY:
        begin
          cnt_d = cnt_q - 8'd1;
          if (cnt_q == len_q - AHS_LEN_SHORT)
            b0_d = rx_byte;
          else if (cnt_q == len_q - AHS_LEN_SHORT - 8'd1)
            b1_d = rx_byte;
          if (cnt_q == 8'd1)
          begin
            st_d = AHS_ST_DEST;
            if (len_q == AHS_LEN_WORD && cat_q == AHS_CAT_SETUP && fn_q == AHS_FN_SLEW)
            begin
              sf_d = {b0_q, rx_byte};
              ack_d = 1'b1;
            end
            else if (cat_q == AHS_CAT_VEL && fn_q == AHS_FN_VEL && len_q == AHS_LEN_WORD + 8'd1
                     && rx_byte == 8'(b0_q + b1_q))
            begin
              vel_d = {b0_q, b1_q};
              ext_d = 1'b1;
            end
          end
        end
        AHS_ST_SKIP:
        begin
          cnt_d = cnt_q - 8'd1;
          if (cnt_q == 8'd1)
            st_d = AHS_ST_DEST;
        end
        default:
          st_d = AHS_ST_DEST;
      endcase
    end
    spd_d = ext_d ? vel_d : dflt;
    // Own flop so the mode output never glitches off combinational logic
    red_d = !ext_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st_q <= AHS_ST_DEST;
      len_q <= 8'h00_00;
      cat_q <= 8'h00_00;
      fn_q <= 8'h00_00;
      cnt_q <= 8'h00_00;
      b0_q <= 8'h00_00;
      b1_q <= 8'h00_00;
      xg_q <= 16'h00_00;
      zg_q <= 16'h00_00;
      yg_q <= 16'h00_00;
      sf_q <= AHS_SLEW_RST;
      vel_q <= 16'h00_00;
      spd_q <= AHS_SPD_MED;
      ext_q <= 1'b0;
      lvl_q <= 1'b0;
      ack_q <= 1'b0;
      up_q <= 32'h0000_0000;
      busy_q <= 1'b1;
      red_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      len_q <= len_d;
      cat_q <= cat_d;
      fn_q <= fn_d;
      cnt_q <= cnt_d;
      b0_q <= b0_d;
      b1_q <= b1_d;
      xg_q <= xg_d;
      zg_q <= zg_d;
      yg_q <= yg_d;
      sf_q <= sf_d;
      vel_q <= vel_d;
      spd_q <= spd_d;
      ext_q <= ext_d;
      lvl_q <= lvl_d;
      ack_q <= ack_d;
      up_q <= up_d;
      busy_q <= busy_d;
      red_q <= red_d;
    end
  end

  assign level_req = lvl_q;
  assign startup_busy = busy_q;
  assign x_one_g = xg_q;
  assign z_zero_g = zg_q;
  assign y_one_g = yg_q;
  assign slew_factor_word = sf_q;
  assign speed_mph = spd_q;
  assign vel_external = ext_q;
  assign reduced_comp = red_q;
  assign ack_pulse = ack_q;
endmodule
`default_nettype wire

// *** ahs_pkg.sv ***
// Constants and types for the setup command handler
`default_nettype none
package ahs_pkg;
  localparam logic [7:0] AHS_DEST_IMU = 8'h00_E6;
  localparam logic [7:0] AHS_CAT_SETUP = 8'h00_35;
  localparam logic [7:0] AHS_CAT_VEL = 8'h00_01;
  localparam logic [7:0] AHS_FN_VEL = 8'h00_80;
  localparam logic [7:0] AHS_FN_LEVEL = 8'h00_0C;
  localparam logic [7:0] AHS_FN_XCAL = 8'h00_0D;
  localparam logic [7:0] AHS_FN_YCAL = 8'h00_0E;
  localparam logic [7:0] AHS_FN_SLEW = 8'h00_10;
  localparam logic [7:0] AHS_LEN_SHORT = 8'h00_02;
  localparam logic [7:0] AHS_LEN_WORD = 8'h00_04;
  localparam logic [15:0] AHS_SLEW_RST = 16'h00_C8;
  localparam logic [15:0] AHS_SF_LOW = 16'h00_64;
  localparam logic [15:0] AHS_SF_MED = 16'h00_C8;
  localparam logic [15:0] AHS_SF_HIGH = 16'h01_2C;
  localparam logic [15:0] AHS_SF_TOP = 16'h01_F4;
  localparam logic [15:0] AHS_SPD_LOWEST = 16'h00_32;
  localparam logic [15:0] AHS_SPD_LOW = 16'h00_46;
  localparam logic [15:0] AHS_SPD_MED = 16'h00_64;
  localparam logic [15:0] AHS_SPD_HIGH = 16'h00_8C;
  localparam logic [15:0] AHS_SPD_TOP = 16'h00_C8;
  localparam longint AHS_CLK_HZ = 200_000_000;
  localparam longint AHS_STARTUP_S = 15;
  localparam longint AHS_STARTUP_CYC = AHS_STARTUP_S * AHS_CLK_HZ;
  typedef enum logic [2:0] {AHS_ST_DEST, AHS_ST_LEN, AHS_ST_CAT, AHS_ST_FN, AHS_ST_PAY, AHS_ST_SKIP} ahs_state_t;
endpackage
`default_nettype wire

// *** ahs_asserts.sv ***
// Checker for the setup command handler ports
`default_nettype none
module ahs_asserts
(
  // Clock, reset and link
  input wire logic mclk,
  input wire logic rstn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Sensors
  input wire logic [15:0] accel_x,
  input wire logic [15:0] accel_y,
  input wire logic [15:0] accel_z,
  // Outputs
  input wire logic level_req,
  input wire logic startup_busy,
  input wire logic [15:0] x_one_g,
  input wire logic [15:0] z_zero_g,
  input wire logic [15:0] y_one_g,
  input wire logic [15:0] slew_factor_word,
  input wire logic [15:0] speed_mph,
  input wire logic vel_external,
  input wire logic reduced_comp,
  input wire logic ack_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Only back-to-back frames are recognised, so gapped traffic goes unchecked
  sequence f4(b0, b1, b2, b3);
    rx_valid && rx_byte == b0 ##1 rx_valid && rx_byte == b1 ##1 rx_valid && rx_byte == b2 ##1 rx_valid && rx_byte == b3;
  endsequence
  function automatic logic [15:0] dspd(input logic [15:0] s);
    return s < 16'h0064 ? 16'h0032 : s < 16'h00C8 ? 16'h0046 : s < 16'h012C ? 16'h0064 : s < 16'h01F4 ? 16'h008C : 16'h00C8;
  endfunction
  a_level_ack: assert property (f4(8'hE6, 8'h02, 8'h35, 8'h0C) |=> level_req && ack_pulse) else $error("level");
  a_xcal_cap: assert property (f4(8'hE6, 8'h02, 8'h35, 8'h0D) |=> ack_pulse && x_one_g == $past(accel_x)
    && z_zero_g == $past(accel_z)) else $error("xcal");
  a_ycal_cap: assert property (f4(8'hE6, 8'h02, 8'h35, 8'h0E) |=> ack_pulse && y_one_g == $past(accel_y)) else $error("ycal");
  a_slew_store: assert property (f4(8'hE6, 8'h04, 8'h35, 8'h10) ##1 rx_valid ##1 rx_valid |=> ack_pulse
    && slew_factor_word == {$past(rx_byte, 2), $past(rx_byte)}) else $error("slew");
  a_dflt_speed: assert property (!vel_external && !$past(vel_external) && $stable(slew_factor_word)
    |-> speed_mph == dspd(slew_factor_word)) else $error("speed");
  a_reduced_mode: assert property (reduced_comp == !vel_external) else $error("reduced");
  a_start_level: assert property ($fell(startup_busy) |-> ##[0:1] level_req) else $error("startup");
  a_drop_dest: assert property (f4(8'hE5, 8'h02, 8'h35, 8'h0C) |=> !ack_pulse) else $error("dest");
endmodule
bind ahs_setup_cmd ahs_asserts chk_u (.*);
`default_nettype wire

// *** ahs_host.sv ***
// Host instrument model sending setup and velocity frames
`default_nettype none
module ahs_host
(
  // Link
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Byte order fixed, payload count from length; idle line shows the inverse
  task automatic frame(input logic [7:0] d, l, c, f, input logic [15:0] w, input logic [7:0] k);
    logic [7:0] b [7];
    b = '{d, l, c, f, w[15:8], w[7:0], k};
    for (int i = 0; i < l + 2; i++)
    begin
      @(posedge mclk) #1;
      rx_valid = 1'b1;
      rx_byte = b[i];
    end
    @(posedge mclk) #1;
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;
  endtask
  task automatic vel(input logic [15:0] s, input logic [7:0] bad);
    frame(8'hE6, 8'h05, 8'h01, 8'h80, s, s[15:8] + s[7:0] + bad);
  endtask
endmodule
`default_nettype wire

// *** ahs_tb.sv ***
// Self-checking bench for the setup command handler
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rstn = 1'b0, bias_done = 1'b0, vel_lost = 1'b0;
  logic [15:0] accel_x = 16'h0101, accel_y = 16'h0202, accel_z = 16'h0303;
  logic rx_valid, level_req, startup_busy, vel_external, reduced_comp, ack_pulse;
  logic [7:0] rx_byte;
  logic [15:0] x_one_g, z_zero_g, y_one_g, slew_factor_word, speed_mph;
  int errors = 0, samples_checked = 0, cyc = 0, acks = 0, lvls = 0;
  always #2.5 mclk = ~mclk;
  // Pulses counted mid-cycle, away from the edge that launches them
  always @(negedge mclk)
  begin
    cyc++;
    acks += (ack_pulse === 1'b1);
    lvls += (level_req === 1'b1);
    if (cyc == 5000)
    begin
      errors++;
      end_sim();
    end
  end
  ahs_host host_u (.mclk, .rx_valid, .rx_byte);
  ahs_setup_cmd #(.STARTUP_CYC(50)) dut_u (.mclk, .rstn, .rx_valid, .rx_byte, .accel_x, .accel_y, .accel_z,
    .bias_done, .vel_lost, .level_req, .startup_busy, .x_one_g, .z_zero_g, .y_one_g, .slew_factor_word,
    .speed_mph, .vel_external, .reduced_comp, .ack_pulse);
  task automatic wt();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic t_start();
    `CHK(slew_factor_word, 16'h00C8)
    `CHK(speed_mph, 16'h0064)
    `CHK(startup_busy, 1'b1)
    repeat (55) @(posedge mclk);
    #1;
    `CHK(startup_busy, 1'b0)
    `CHK(lvls, 1)
  endtask
  task automatic t_cmds();
    host_u.frame(8'hE6, 8'h02, 8'h35, 8'h0C, 16'h0000, 8'h00);
    host_u.frame(8'hE6, 8'h02, 8'h35, 8'h0D, 16'h0000, 8'h00);
    accel_x = 16'h0A0A;
    accel_z = 16'h0C0C;
    host_u.frame(8'hE6, 8'h02, 8'h35, 8'h0E, 16'h0000, 8'h00);
    accel_y = 16'h0B0B;
    wt();
    `CHK(lvls, 2)
    `CHK(x_one_g, 16'h0101)
    `CHK(z_zero_g, 16'h0303)
    `CHK(y_one_g, 16'h0202)
    `CHK(acks, 3)
    host_u.frame(8'hE5, 8'h02, 8'h35, 8'h0C, 16'h0000, 8'h00);
    host_u.frame(8'hE6, 8'h02, 8'h36, 8'h0C, 16'h0000, 8'h00);
    wt();
    `CHK(acks, 3)
    `CHK(lvls, 2)
  endtask
  task automatic t_slew();
    logic [15:0] sf [5] = '{16'h0032, 16'h0064, 16'h00C8, 16'h012C, 16'h01F4};
    logic [15:0] sp [5] = '{16'h0032, 16'h0046, 16'h0064, 16'h008C, 16'h00C8};
    for (int i = 0; i < 5; i++)
    begin
      host_u.frame(8'hE6, 8'h04, 8'h35, 8'h10, sf[i], 8'h00);
      wt();
      `CHK(slew_factor_word, sf[i])
      `CHK(speed_mph, sp[i])
    end
  endtask
  task automatic t_vel();
    host_u.vel(16'h0173, 8'h01);
    wt();
    `CHK(vel_external, 1'b0)
    host_u.vel(16'h0173, 8'h00);
    wt();
    `CHK(vel_external, 1'b1)
    `CHK(speed_mph, 16'h0173)
    `CHK(reduced_comp, 1'b0)
    vel_lost = 1'b1;
    wt();
    vel_lost = 1'b0;
    wt();
    `CHK(speed_mph, 16'h00C8)
    `CHK(reduced_comp, 1'b1)
  endtask
  task automatic t_bias();
    rstn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    `CHK(startup_busy, 1'b1)
    `CHK(slew_factor_word, 16'h00C8)
    `CHK(reduced_comp, 1'b1)
    repeat (5) @(posedge mclk);
    #1;
    bias_done = 1'b1;
    @(posedge mclk);
    #1;
    bias_done = 1'b0;
    wt();
    `CHK(startup_busy, 1'b0)
    `CHK(lvls, 3)
  endtask
  task automatic end_sim();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    t_start();
    t_cmds();
    t_slew();
    t_vel();
    t_bias();
    end_sim();
  end
endmodule
`default_nettype wire
